// *** verilog/art_timers.sv ***
// two 8-bit auto-reload timers and a 16-bit auto-reload timer two
`timescale 1ns/1ns
// Function
// - timer zero low byte counts, its high byte holds the reload value
// - count rolling FF to 00 sets timer zero flag and reloads the count
// - enabled timer zero raises its interrupt request while its flag is set
// - the reload byte is never changed by a reload
// - timer one works like timer zero with its own bytes, flag, controls
// - counts when mode is auto-reload, run set, and gate off or gate input at chosen polarity
// - timer two is low plus high byte, split bit picks 16-bit or split
// - timer two clock is sysclk, sysclk/12, rtc/8 or comparator, synced
// - 16-bit rollover loads the reload value and sets the high flag
// - timer two mask and all-enable bit set give an interrupt on every 16-bit overflow outside capture mode
// - with low enable set, low byte rollover also interrupts
// - capture mode measures rtc or comparator period against a clock
// - timer two reload value sits in two software read/write bytes
// - timer two mask passes low or high flag requests, blocks both when 0
module art_timers (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic timer_zero_gate_select_in,
    input wire logic gate1_in,
    input wire logic rtc_osc_in,
    input wire logic cmp_out_in,
    output logic irq_timer0_out,
    output logic irq_timer1_out,
    output logic irq_timer2_out
);
    logic [7:0] count_r [2];
    logic [7:0] reload_r [2];
    logic [1:0] run_r;
    logic [1:0] ovf_flag_r;
    logic [3:0] tctl_low_r;
    logic [7:0] tmode_r;
    logic [7:0] ext_cfg_r;
    logic [7:0] imask_r;
    logic [5:0] t2_ctl_r;
    logic t2_high_flag_r;
    logic t2_low_flag_r;
    logic [7:0] t2_low_r;
    logic [7:0] t2_high_r;
    logic [7:0] t2_rld_low_r;
    logic [7:0] t2_rld_high_r;
    logic [3:0] div12_r;
    logic [2:0] rtc_div_r;
    logic [7:0] rdata_nxt;
    logic [2:0] irq_r;

    function automatic logic wr_at(input logic [7:0] a, input logic [7:0] t);
        wr_at = (a == t);
    endfunction

    // synchronised pins: timer_zero_gate_select, gate1, rtc, comparator
    logic [3:0] pin_raw;
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    assign pin_raw = {cmp_out_in, rtc_osc_in, gate1_in, timer_zero_gate_select_in};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            art_sync_edge u_sync (
                .clk_sys_in(clk_sys_in),
                .rst_in(rst_in),
                .async_in(pin_raw[gi]),
                .level_out(pin_lvl[gi]),
                .rise_out(pin_rise[gi])
            );
        end
    endgenerate

    logic wr_tctl;
    assign wr_tctl = sfr_wr_in & wr_at(sfr_addr_in, art_pkg::ADDR_TCTL);

    // timers zero and one, auto-reload mode
    logic [1:0] t_ovf;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            localparam int MB = gi * art_pkg::TMODE_STRIDE;
            localparam int FB = art_pkg::TCTL_OVF_BASE + 2 * gi;
            localparam int RB = art_pkg::TCTL_RUN_BASE + 2 * gi;
            localparam logic [7:0] CNT_A = gi == 0 ? art_pkg::ADDR_T0_COUNT
                                                   : art_pkg::ADDR_T1_COUNT;
            localparam logic [7:0] RLD_A = gi == 0 ? art_pkg::ADDR_T0_RELOAD
                                                   : art_pkg::ADDR_T1_RELOAD;
            logic gate_ok;
            logic running;
            logic [7:0] cnt_nxt;
            logic flag_nxt;
            assign gate_ok = ~tmode_r[MB + art_pkg::TMODE_GATE]
                | (pin_lvl[gi] == ext_cfg_r[MB + art_pkg::EXT_POL]);
            assign running = run_r[gi] & gate_ok
                & (tmode_r[MB+1:MB] == art_pkg::MODE_AUTO_RELOAD);
            assign t_ovf[gi] = running
                & (count_r[gi] == art_pkg::BYTE_ALL_ONES);
            assign cnt_nxt = (sfr_wr_in & wr_at(sfr_addr_in, CNT_A))
                ? sfr_wdata_in
                : t_ovf[gi] ? reload_r[gi]
                : running ? count_r[gi] + 8'h01 : count_r[gi];
            // set wins over a software clear in the same cycle
            assign flag_nxt = t_ovf[gi] ? 1'b1
                : wr_tctl ? sfr_wdata_in[FB] : ovf_flag_r[gi];
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    count_r[gi] <= art_pkg::REG_RESET;
                    reload_r[gi] <= art_pkg::REG_RESET;
                    run_r[gi] <= 1'b0;
                    ovf_flag_r[gi] <= 1'b0;
                end else begin
                    count_r[gi] <= cnt_nxt;
                    // only software writes the reload byte
                    if (sfr_wr_in & wr_at(sfr_addr_in, RLD_A)) begin
                        reload_r[gi] <= sfr_wdata_in;
                    end
                    if (wr_tctl) begin
                        run_r[gi] <= sfr_wdata_in[RB];
                    end
                    ovf_flag_r[gi] <= flag_nxt;
                end
            end
        end
    endgenerate

    // timer two clock sources
    art_pkg::art_clk_sel_t clk_sel;
    logic tick12;
    logic tick_rtc;
    logic src_tick;
    assign clk_sel = art_pkg::art_clk_sel_t'(t2_ctl_r[1:0]);
    assign tick12 = (div12_r == 4'(art_pkg::SYS_DIV - 1));
    assign tick_rtc = pin_rise[2]
        & (rtc_div_r == 3'(art_pkg::RTC_DIV - 1));
    assign src_tick = (clk_sel == art_pkg::ART_CLK_SYS) ? 1'b1
        : (clk_sel == art_pkg::ART_CLK_SYS_DIV) ? tick12
        : (clk_sel == art_pkg::ART_CLK_RTC_DIV) ? tick_rtc
        : pin_rise[3];

    // capture mode counts sysclk or sysclk/12 and samples on rtc/8 or cmp
    logic capture;
    logic split;
    logic t2_run;
    logic t2_tick;
    logic cap_event;
    assign capture = t2_ctl_r[art_pkg::T2_CAPTURE];
    assign split = t2_ctl_r[art_pkg::T2_SPLIT];
    assign t2_run = t2_ctl_r[art_pkg::T2_RUN];
    assign t2_tick = t2_run & (capture ? (clk_sel[0] ? tick12 : 1'b1)
                                       : src_tick);
    assign cap_event = t2_run & capture
        & (clk_sel[1] ? pin_rise[3] : tick_rtc);

    logic low_ovf;
    logic high_ovf;
    logic full_ovf;
    logic reload16;
    logic [7:0] t2_low_nxt;
    logic [7:0] t2_high_nxt;
    logic [7:0] rld_low_nxt;
    logic [7:0] rld_high_nxt;
    logic t2_high_flag_nxt;
    logic t2_low_flag_nxt;
    logic wr_t2_ctl;
    assign low_ovf = t2_tick & (t2_low_r == art_pkg::BYTE_ALL_ONES);
    assign high_ovf = t2_tick & (t2_high_r == art_pkg::BYTE_ALL_ONES);
    assign full_ovf = low_ovf & (t2_high_r == art_pkg::BYTE_ALL_ONES);
    assign reload16 = full_ovf & ~split & ~capture;
    assign t2_low_nxt = (sfr_wr_in
            & wr_at(sfr_addr_in, art_pkg::ADDR_T2_CNT_LOW)) ? sfr_wdata_in
        : (reload16 | (split & ~capture & low_ovf)) ? t2_rld_low_r
        : t2_tick ? t2_low_r + 8'h01 : t2_low_r;
    assign t2_high_nxt = (sfr_wr_in
            & wr_at(sfr_addr_in, art_pkg::ADDR_T2_CNT_HIGH)) ? sfr_wdata_in
        : (reload16 | (split & ~capture & high_ovf)) ? t2_rld_high_r
        : (split & ~capture) ? (t2_tick ? t2_high_r + 8'h01 : t2_high_r)
        : low_ovf ? t2_high_r + 8'h01 : t2_high_r;
    // capture copies the running count into the reload bytes
    assign rld_low_nxt = cap_event ? t2_low_r
        : (sfr_wr_in & wr_at(sfr_addr_in, art_pkg::ADDR_T2_RLD_LOW))
        ? sfr_wdata_in : t2_rld_low_r;
    assign rld_high_nxt = cap_event ? t2_high_r
        : (sfr_wr_in & wr_at(sfr_addr_in, art_pkg::ADDR_T2_RLD_HIGH))
        ? sfr_wdata_in : t2_rld_high_r;
    assign wr_t2_ctl = sfr_wr_in & wr_at(sfr_addr_in, art_pkg::ADDR_T2_CTL);
    assign t2_high_flag_nxt = (reload16 | cap_event
            | (split & ~capture & high_ovf)) ? 1'b1
        : wr_t2_ctl ? sfr_wdata_in[art_pkg::T2_HIGH_FLAG] : t2_high_flag_r;
    assign t2_low_flag_nxt = low_ovf ? 1'b1
        : wr_t2_ctl ? sfr_wdata_in[art_pkg::T2_LOW_FLAG] : t2_low_flag_r;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            t2_low_r <= art_pkg::REG_RESET;
            t2_high_r <= art_pkg::REG_RESET;
            t2_rld_low_r <= art_pkg::REG_RESET;
            t2_rld_high_r <= art_pkg::REG_RESET;
            t2_high_flag_r <= 1'b0;
            t2_low_flag_r <= 1'b0;
            t2_ctl_r <= 6'h00;
        end else begin
            t2_low_r <= t2_low_nxt;
            t2_high_r <= t2_high_nxt;
            t2_rld_low_r <= rld_low_nxt;
            t2_rld_high_r <= rld_high_nxt;
            t2_high_flag_r <= t2_high_flag_nxt;
            t2_low_flag_r <= t2_low_flag_nxt;
            if (wr_t2_ctl) begin
                t2_ctl_r <= sfr_wdata_in[5:0];
            end
        end
    end

    // clock dividers for timer two
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            div12_r <= 4'h0;
            rtc_div_r <= 3'h0;
        end else begin
            div12_r <= tick12 ? 4'h0 : div12_r + 4'h1;
            if (pin_rise[2]) begin
                rtc_div_r <= rtc_div_r + 3'h1;
            end
        end
    end

    // plain configuration registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            tctl_low_r <= 4'h0;
            tmode_r <= art_pkg::REG_RESET;
            ext_cfg_r <= art_pkg::REG_RESET;
            imask_r <= art_pkg::REG_RESET;
        end else begin
            if (wr_tctl) begin
                tctl_low_r <= sfr_wdata_in[3:0];
            end
            if (sfr_wr_in & wr_at(sfr_addr_in, art_pkg::ADDR_TMODE)) begin
                tmode_r <= sfr_wdata_in;
            end
            if (sfr_wr_in & wr_at(sfr_addr_in, art_pkg::ADDR_EXT_CFG)) begin
                ext_cfg_r <= sfr_wdata_in;
            end
            if (sfr_wr_in & wr_at(sfr_addr_in, art_pkg::ADDR_IMASK)) begin
                imask_r <= sfr_wdata_in;
            end
        end
    end

    // interrupt requests follow the flags while enabled
    logic [2:0] irq_nxt;
    logic all_en;
    assign all_en = imask_r[art_pkg::IMASK_ALL];
    assign irq_nxt[0] = all_en & imask_r[art_pkg::IMASK_T0]
        & ovf_flag_r[0];
    assign irq_nxt[1] = all_en
        & imask_r[art_pkg::IMASK_T0 + art_pkg::IMASK_STRIDE]
        & ovf_flag_r[1];
    assign irq_nxt[2] = all_en & imask_r[art_pkg::IMASK_T2]
        & (t2_high_flag_r | (t2_low_flag_r
        & t2_ctl_r[art_pkg::T2_LOW_INT_EN]));

    // read decode
    always_comb begin
        rdata_nxt = 8'h00;
        if (sfr_addr_in == art_pkg::ADDR_TCTL) begin
            rdata_nxt = {ovf_flag_r[1], run_r[1], ovf_flag_r[0], run_r[0],
                         tctl_low_r};
        end else if (sfr_addr_in == art_pkg::ADDR_TMODE) begin
            rdata_nxt = tmode_r;
        end else if (sfr_addr_in == art_pkg::ADDR_T0_COUNT) begin
            rdata_nxt = count_r[0];
        end else if (sfr_addr_in == art_pkg::ADDR_T1_COUNT) begin
            rdata_nxt = count_r[1];
        end else if (sfr_addr_in == art_pkg::ADDR_T0_RELOAD) begin
            rdata_nxt = reload_r[0];
        end else if (sfr_addr_in == art_pkg::ADDR_T1_RELOAD) begin
            rdata_nxt = reload_r[1];
        end else if (sfr_addr_in == art_pkg::ADDR_IMASK) begin
            rdata_nxt = imask_r;
        end else if (sfr_addr_in == art_pkg::ADDR_T2_CTL) begin
            rdata_nxt = {t2_high_flag_r, t2_low_flag_r, t2_ctl_r};
        end else if (sfr_addr_in == art_pkg::ADDR_T2_RLD_LOW) begin
            rdata_nxt = t2_rld_low_r;
        end else if (sfr_addr_in == art_pkg::ADDR_T2_RLD_HIGH) begin
            rdata_nxt = t2_rld_high_r;
        end else if (sfr_addr_in == art_pkg::ADDR_T2_CNT_LOW) begin
            rdata_nxt = t2_low_r;
        end else if (sfr_addr_in == art_pkg::ADDR_T2_CNT_HIGH) begin
            rdata_nxt = t2_high_r;
        end else if (sfr_addr_in == art_pkg::ADDR_EXT_CFG) begin
            rdata_nxt = ext_cfg_r;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sfr_rdata_out <= 8'h00;
            irq_r <= 3'h0;
        end else begin
            sfr_rdata_out <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign irq_timer0_out = irq_r[0];
    assign irq_timer1_out = irq_r[1];
    assign irq_timer2_out = irq_r[2];
endmodule // art_timers

// *** verilog/art_pkg.sv ***
// constants shared by the auto-reload timer block
package art_pkg;
    // special-function register addresses
    localparam logic [7:0] ADDR_TCTL = 8'h88;
    localparam logic [7:0] ADDR_TMODE = 8'h89;
    localparam logic [7:0] ADDR_T0_COUNT = 8'h8A;
    localparam logic [7:0] ADDR_T1_COUNT = 8'h8B;
    localparam logic [7:0] ADDR_T0_RELOAD = 8'h8C;
    localparam logic [7:0] ADDR_T1_RELOAD = 8'h8D;
    localparam logic [7:0] ADDR_IMASK = 8'hA8;
    localparam logic [7:0] ADDR_T2_CTL = 8'hC8;
    localparam logic [7:0] ADDR_T2_RLD_LOW = 8'hCA;
    localparam logic [7:0] ADDR_T2_RLD_HIGH = 8'hCB;
    localparam logic [7:0] ADDR_T2_CNT_LOW = 8'hCC;
    localparam logic [7:0] ADDR_T2_CNT_HIGH = 8'hCD;
    localparam logic [7:0] ADDR_EXT_CFG = 8'hE4;
    // reset value of every register
    localparam logic [7:0] REG_RESET = 8'h00;
    // timer control: timer n flag at OVF_BASE+2n, run at RUN_BASE+2n
    localparam int TCTL_OVF_BASE = 5;
    localparam int TCTL_RUN_BASE = 4;
    // timer mode: timer n fields start at 4n
    localparam int TMODE_STRIDE = 4;
    localparam int TMODE_GATE = 3;
    localparam logic [1:0] MODE_AUTO_RELOAD = 2'h2;
    // external input config: polarity of gate n at 3+4n
    localparam int EXT_POL = 3;
    // interrupt mask register
    localparam int IMASK_ALL = 7;
    localparam int IMASK_T2 = 5;
    localparam int IMASK_T0 = 1;
    localparam int IMASK_STRIDE = 2;
    // timer two control
    localparam int T2_HIGH_FLAG = 7;
    localparam int T2_LOW_FLAG = 6;
    localparam int T2_LOW_INT_EN = 5;
    localparam int T2_CAPTURE = 4;
    localparam int T2_SPLIT = 3;
    localparam int T2_RUN = 2;
    // timer two clock dividers
    localparam int SYS_DIV = 12;
    localparam int RTC_DIV = 8;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
    typedef enum logic [1:0] {
        ART_CLK_SYS = 2'h0,
        ART_CLK_SYS_DIV = 2'h1,
        ART_CLK_RTC_DIV = 2'h2,
        ART_CLK_CMP = 2'h3
    } art_clk_sel_t;
endpackage

// *** verilog/art_sync_edge.sv ***
// two-flop synchroniser with rising-edge detect
`timescale 1ns/1ns
module art_sync_edge (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level_out = sync_r;
    assign rise_out = sync_r & ~prev_r;
endmodule // art_sync_edge

// *** tb/art_timers_asserts.sv ***
// concurrent checks on the ports of the auto-reload timer block
`timescale 1ns/1ns
module art_timers_asserts (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic timer_zero_gate_select_in,
    input wire logic gate1_in,
    input wire logic rtc_osc_in,
    input wire logic cmp_out_in,
    input wire logic irq_timer0_out,
    input wire logic irq_timer1_out,
    input wire logic irq_timer2_out
);
    logic [7:0] mask_r;
    logic [7:0] rl0_r;
    logic [7:0] rll_r;
    logic [7:0] rlh_r;
    logic cap_r;
    logic okl_r;
    logic okh_r;
    wire mapped = sfr_addr_in inside {8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C,
        8'h8D, 8'hA8, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hE4};
    wire wr_mask = sfr_wr_in && sfr_addr_in == art_pkg::ADDR_IMASK;
    wire wr_rl0 = sfr_wr_in && sfr_addr_in == art_pkg::ADDR_T0_RELOAD;
    wire wr_rll = sfr_wr_in && sfr_addr_in == art_pkg::ADDR_T2_RLD_LOW;
    wire wr_rlh = sfr_wr_in && sfr_addr_in == art_pkg::ADDR_T2_RLD_HIGH;
    wire wr_t2ctl = sfr_wr_in && sfr_addr_in == art_pkg::ADDR_T2_CTL;
    // software copies; capture may overwrite the timer two reload bytes,
    // so those copies are trusted from reset until capture is on, then again after a write with capture off
    always_ff @(posedge clk_sys_in) begin
        mask_r <= rst_in ? 8'h00 : (wr_mask ? sfr_wdata_in : mask_r);
        rl0_r <= rst_in ? 8'h00 : (wr_rl0 ? sfr_wdata_in : rl0_r);
        rll_r <= rst_in ? 8'h00 : (wr_rll ? sfr_wdata_in : rll_r);
        rlh_r <= rst_in ? 8'h00 : (wr_rlh ? sfr_wdata_in : rlh_r);
        cap_r <= rst_in ? 1'b0
            : (wr_t2ctl ? sfr_wdata_in[art_pkg::T2_CAPTURE] : cap_r);
        okl_r <= rst_in ? 1'b1 : (cap_r ? 1'b0 : (wr_rll ? 1'b1 : okl_r));
        okh_r <= rst_in ? 1'b1 : (cap_r ? 1'b0 : (wr_rlh ? 1'b1 : okh_r));
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    AST_UNMAPPED_ZERO:
        assert property (!mapped |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    AST_IRQ0_MASKED:
        assert property (irq_timer0_out |-> $past(mask_r[7] && mask_r[1]))
        else $error("timer zero request while masked");
    AST_IRQ1_MASKED:
        assert property (irq_timer1_out |-> $past(mask_r[7] && mask_r[3]))
        else $error("timer one request while masked");
    AST_IRQ2_MASKED:
        assert property (irq_timer2_out |-> $past(mask_r[7] && mask_r[5]))
        else $error("timer two request while masked");
    AST_T0_RELOAD_KEPT:
        assert property (sfr_addr_in == 8'h8C && !sfr_wr_in
            |=> sfr_rdata_out == rl0_r)
        else $error("timer zero reload byte altered");
    AST_T2_RLD_LOW:
        assert property (sfr_addr_in == 8'hCA && !sfr_wr_in && okl_r
            |=> sfr_rdata_out == rll_r)
        else $error("timer two reload low mismatch");
    AST_T2_RLD_HIGH:
        assert property (sfr_addr_in == 8'hCB && !sfr_wr_in && okh_r
            |=> sfr_rdata_out == rlh_r)
        else $error("timer two reload high mismatch");
    AST_T2_STICKY:
        assert property (irq_timer2_out && !$past(sfr_wr_in)
            |=> irq_timer2_out)
        else $error("timer two request dropped without a write");
    AST_T0_STICKY:
        assert property (irq_timer0_out && !$past(sfr_wr_in)
            |=> irq_timer0_out)
        else $error("timer zero request dropped without a write");
endmodule // art_timers_asserts

bind art_timers art_timers_asserts art_timers_asserts_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out), .timer_zero_gate_select_in(timer_zero_gate_select_in), .gate1_in(gate1_in),
    .rtc_osc_in(rtc_osc_in), .cmp_out_in(cmp_out_in),
    .irq_timer0_out(irq_timer0_out), .irq_timer1_out(irq_timer1_out),
    .irq_timer2_out(irq_timer2_out));

// *** tb/art_timers_tb.sv ***
// self-checking testbench for the auto-reload timer block
`timescale 1ns/1ns
module art_timers_tb;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic sfr_wr_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [7:0] sfr_rdata_out;
    logic timer_zero_gate_select_in = 1'b0;
    logic gate1_in = 1'b0;
    logic rtc_osc_in = 1'b0;
    logic cmp_out_in = 1'b0;
    logic irq_timer0_out, irq_timer1_out, irq_timer2_out;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] d;
    art_timers art_timers_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
        .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
        .timer_zero_gate_select_in(timer_zero_gate_select_in), .gate1_in(gate1_in), .rtc_osc_in(rtc_osc_in),
        .cmp_out_in(cmp_out_in), .irq_timer0_out(irq_timer0_out),
        .irq_timer1_out(irq_timer1_out), .irq_timer2_out(irq_timer2_out));
    always #4 clk_sys_in = ~clk_sys_in;
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys_in);
        sfr_addr_in = a;
        sfr_wdata_in = v;
        sfr_wr_in = 1'b1;
        @(negedge clk_sys_in);
        sfr_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys_in);
        sfr_addr_in = a;
        @(negedge clk_sys_in);
        d = sfr_rdata_out;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_regs();
        logic [7:0] a[5] = '{8'h8A, 8'h8B, 8'hCA, 8'hCB, 8'h55};
        foreach (a[i]) begin
            rd(a[i]);
            chk(d, 8'h00);
            wr(a[i], 8'h5A);
            rd(a[i]);
            chk(d, (a[i] == 8'h55) ? 8'h00 : 8'h5A);
            wr(a[i], 8'h00);
        end
        $display("done: register access");
    endtask
    task automatic t_auto8(input int n);
        logic [7:0] fl;
        fl = 8'h20 << (2 * n);
        wr(8'h8C + 8'(n), 8'hF0);
        wr(8'h89, 8'h22);
        wr(8'h8A + 8'(n), 8'hFE);
        wr(8'hA8, 8'h80 | (8'h02 << (2 * n)));
        wr(8'h88, fl >> 1);
        idle(10);
        rd(8'h88);
        chk(d, fl | (fl >> 1));
        wr(8'h88, fl);
        rd(8'h88);
        chk(d, fl);
        rd(8'h8A + 8'(n));
        chk({4'h0, d[7:4]}, 8'h0F);
        rd(8'h8C + 8'(n));
        chk(d, 8'hF0);
        chk({7'h0, n ? irq_timer1_out : irq_timer0_out}, 8'h01);
        wr(8'hA8, 8'h80);
        idle(2);
        chk({7'h0, n ? irq_timer1_out : irq_timer0_out}, 8'h00);
        wr(8'h88, 8'h00);
        wr(8'hA8, 8'hAA);
        idle(2);
        chk({7'h0, n ? irq_timer1_out : irq_timer0_out}, 8'h00);
        wr(8'hA8, 8'h00);
        $display("done: 8-bit auto-reload timer %0d", n);
    endtask
    task automatic t_gate();
        logic [7:0] c1;
        wr(8'h89, 8'h0A);
        wr(8'hE4, 8'h08);
        wr(8'h8A, 8'h10);
        wr(8'h88, 8'h10);
        idle(8);
        rd(8'h8A);
        chk(d, 8'h10);
        timer_zero_gate_select_in = 1'b1;
        idle(8);
        rd(8'h8A);
        chk({7'h0, d > 8'h10 && d < 8'h20}, 8'h01);
        wr(8'hE4, 8'h00);
        idle(4);
        rd(8'h8A);
        c1 = d;
        idle(6);
        rd(8'h8A);
        chk(d, c1);
        wr(8'h88, 8'h00);
        $display("done: gate control");
    endtask
    task automatic t_t2();
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        wr(8'hCC, 8'hFE);
        wr(8'hCD, 8'hFF);
        wr(8'hA8, 8'hA0);
        wr(8'hC8, 8'h24);
        idle(6);
        rd(8'hC8);
        chk(d & 8'hC0, 8'hC0);
        rd(8'hCD);
        chk(d, 8'h12);
        chk({7'h0, irq_timer2_out}, 8'h01);
        idle(20);
        rd(8'hC8);
        chk(d & 8'hC0, 8'hC0);
        wr(8'hA8, 8'h80);
        idle(2);
        chk({7'h0, irq_timer2_out}, 8'h00);
        wr(8'hC8, 8'h00);
        wr(8'hA8, 8'hA0);
        wr(8'hCD, 8'h00);
        wr(8'hCC, 8'hFE);
        wr(8'hC8, 8'h04);
        idle(6);
        rd(8'hC8);
        chk(d & 8'hC0, 8'h40);
        chk({7'h0, irq_timer2_out}, 8'h00);
        wr(8'hCC, 8'hF0);
        wr(8'hC8, 8'h24);
        idle(20);
        chk({7'h0, irq_timer2_out}, 8'h01);
        wr(8'hC8, 8'h00);
        wr(8'hCD, 8'hFE);
        wr(8'hCC, 8'hFE);
        wr(8'hC8, 8'h0C);
        idle(4);
        rd(8'hC8);
        chk(d & 8'hC0, 8'hC0);
        rd(8'hCD);
        chk({4'h0, d[7:4]}, 8'h01);
        wr(8'hC8, 8'h00);
        wr(8'hA8, 8'h00);
        $display("done: timer two 16-bit");
    endtask
    task automatic t_clk();
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h05);
        idle(120);
        wr(8'hC8, 8'h00);
        rd(8'hCC);
        chk({7'h0, d >= 8'h09 && d <= 8'h0B}, 8'h01);
        for (int s = 2; s < 4; s++) begin
            wr(8'hCC, 8'h00);
            wr(8'hC8, 8'h04 | 8'(s));
            repeat (s == 2 ? 16 : 3) begin
                if (s == 2) rtc_osc_in = 1'b1;
                else cmp_out_in = 1'b1;
                idle(2);
                rtc_osc_in = 1'b0;
                cmp_out_in = 1'b0;
                idle(2);
            end
            idle(4);
            wr(8'hC8, 8'h00);
            rd(8'hCC);
            chk(d, s == 2 ? 8'h02 : 8'h03);
        end
        $display("done: timer two clock sources");
    endtask
    task automatic t_cap();
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        wr(8'hC8, 8'h17);
        idle(60);
        cmp_out_in = 1'b1;
        idle(2);
        cmp_out_in = 1'b0;
        idle(4);
        rd(8'hC8);
        chk(d & 8'h80, 8'h80);
        wr(8'hC8, 8'h00);
        rd(8'hCB);
        chk(d, 8'h00);
        rd(8'hCA);
        chk({7'h0, d >= 8'h04 && d <= 8'h07}, 8'h01);
        $display("done: timer two capture");
    endtask
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        idle(8);
        rst_in = 1'b0;
        t_regs();
        t_auto8(0);
        t_auto8(1);
        t_gate();
        t_t2();
        t_clk();
        t_cap();
        print_verdict();
    end
endmodule // art_timers_tb
